// >>> hw/ctc_defs.vh
// Constants for the capture/compare timer register block
`ifndef CTC_DEFS_VH
`define CTC_DEFS_VH

// Register offsets in the extended function register space
`define CTC_ADDR_CTRL 8'hC0
`define CTC_ADDR_CAP1_HI 8'hC1
`define CTC_ADDR_CAP1_LO 8'hC2
`define CTC_ADDR_CAP2_HI 8'hC3
`define CTC_ADDR_CAP2_LO 8'hC4
`define CTC_ADDR_CMP1_HI 8'hC5
`define CTC_ADDR_CMP1_LO 8'hC6
`define CTC_ADDR_ROUTE 8'hC7
`define CTC_ADDR_CMP2_HI 8'hC9
`define CTC_ADDR_CMP2_LO 8'hCA
`define CTC_ADDR_SHD_HI 8'hCB
`define CTC_ADDR_SHD_LO 8'hCC

// Control register fields
`define CTC_CTRL_RATE 0
`define CTC_CTRL_CAP1_EDGE 1
`define CTC_CTRL_CAP2_EDGE 2
`define CTC_CTRL_CMP1_LVL 3
`define CTC_CTRL_CMP2_LVL 4
`define CTC_CTRL_SNAP 5
`define CTC_CTRL_RES_LO 6
`define CTC_CTRL_RES_HI 7

// Pin routing register fields
`define CTC_ROUTE_CAP1 0
`define CTC_ROUTE_CAP2 1
`define CTC_ROUTE_CMP1 2
`define CTC_ROUTE_CMP2 3
`define CTC_ROUTE_USED_MASK 8'h0F

// Reset values
`define CTC_RST_BYTE 8'h00
`define CTC_RST_WORD 16'h0000

// Timing: system clock and the two timer resolutions, in MHz
`define CTC_CLK_MHZ 100
`define CTC_FAST_MHZ 20
`define CTC_SLOW_MHZ 10
`define CTC_FAST_DIV (`CTC_CLK_MHZ / `CTC_FAST_MHZ)
`define CTC_SLOW_DIV (`CTC_CLK_MHZ / `CTC_SLOW_MHZ)
// Last prescaler count of each timer step, sized for the 4-bit prescaler
`define CTC_FAST_LAST 4'h4
`define CTC_SLOW_LAST 4'h9

`endif

// >>> hw/ctc_capture_chan.v
// One input-capture channel: pin synchroniser, edge pick and capture register
`timescale 1ns/10ps
`include "ctc_defs.vh"

module ctc_capture_chan #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // Pin and configuration
    input wire i_pin,
    input wire i_enable,
    input wire i_rising,
    // Timer and result
    input wire [WIDTH-1:0] i_timer,
    output wire [WIDTH-1:0] o_value,
    output wire o_event
);

    reg sync1_ff;
    reg sync2_ff;
    reg sync3_ff;
    reg level_ff;
    reg [WIDTH-1:0] value_ff;
    wire settled;
    wire changed;
    wire hit;

    // Only the second stage reads the first one
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= i_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // A change counts only once stages two and three agree
    assign settled = (sync2_ff == sync3_ff);
    assign changed = settled && (sync3_ff != level_ff);
    assign hit = changed && i_enable && (sync3_ff == i_rising);

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            level_ff <= 1'b0;
            value_ff <= {WIDTH{1'b0}};
        end else begin
            if (changed) begin
                level_ff <= sync3_ff;
            end
            if (hit) begin
                value_ff <= i_timer;
            end
        end
    end

    assign o_value = value_ff;
    assign o_event = hit;

endmodule

// >>> hw/ctc_timer_regs.v
// Capture/compare timer: free-running timer, channels, pin routing, registers
//
// How it works
// - Routing bit 0 ties pin one to capture one
// - Routing bit 1 ties pin two to capture two
// - Routing bit 2 lets compare one drive pin three
// - Routing bit 3 drives pin four; upper bits idle
// - Capture two result readable, high and low bytes
// - Compare one value, writable high/low bytes, reset zero
// - Compare two value, writable high/low bytes, reset zero
// - Timer shadow readable as two bytes, reset zero
// - Edge select: zero falling, one rising
// - Match level bit sets compare output value
// - Writing snapshot one copies timer to shadow
// - Rate bit: clear 20 MHz, set 10 MHz
`timescale 1ns/10ps
`include "ctc_defs.vh"

module ctc_timer_regs #(
    parameter TIMER_WIDTH = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // Special function register port
    input wire [7:0] i_sfr_addr,
    input wire i_sfr_wr,
    input wire [7:0] i_sfr_wdata,
    input wire i_sfr_rd,
    output wire [7:0] o_sfr_rdata,
    // General pins one to four, bit 0 is pin one
    input wire [3:0] i_gpio,
    output wire [3:0] o_gpio,
    output wire [3:0] o_gpio_oe_n,
    output wire [3:0] o_gpio_claimed,
    // Channel events
    output wire o_capture_one_event,
    output wire o_capture_two_event,
    output wire o_compare_one_match,
    output wire o_compare_two_match,
    // Pull-down selection bits kept for the front end
    output wire [1:0] o_pulldown_sel
);

    // ********************************
    // Registers and state
    // ********************************
    reg [7:0] timer_channel_control_ff;
    reg [7:0] timer_pin_routing_ff;
    reg [15:0] compare_one_ff;
    reg [15:0] compare_two_ff;
    reg [15:0] timer_shadow_ff;
    reg [15:0] timer_ff;
    reg [3:0] presc_ff;
    reg tick_d_ff;
    reg [1:0] cmp_out_ff;
    reg [7:0] rdata_ff;
    reg [7:0] nxt_rdata;
    reg [3:0] nxt_presc;
    reg tick;
    wire [15:0] capture_one_value;
    wire [15:0] capture_two_value;
    wire [1:0] cmp_hit;
    wire snap_req;

    wire capture_one_pin_enable = timer_pin_routing_ff[`CTC_ROUTE_CAP1];
    wire capture_two_pin_enable = timer_pin_routing_ff[`CTC_ROUTE_CAP2];
    wire compare_one_pin_enable = timer_pin_routing_ff[`CTC_ROUTE_CMP1];
    wire compare_two_pin_enable = timer_pin_routing_ff[`CTC_ROUTE_CMP2];
    wire timer_rate_select = timer_channel_control_ff[`CTC_CTRL_RATE];

    // ********************************
    // Free-running timer
    // ********************************
    // The prescaler reloads at the end of the current period, so a rate
    // change takes effect within one timer step without glitching the count
    always @* begin
        tick = 1'b0;
        nxt_presc = presc_ff + 4'h1;
        if (timer_rate_select) begin
            if (presc_ff >= `CTC_SLOW_LAST) begin
                tick = 1'b1;
            end
        end else begin
            if (presc_ff >= `CTC_FAST_LAST) begin
                tick = 1'b1;
            end
        end
        if (tick) begin
            nxt_presc = 4'h0;
        end
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            presc_ff <= 4'h0;
            timer_ff <= `CTC_RST_WORD;
            tick_d_ff <= 1'b0;
        end else begin
            presc_ff <= nxt_presc;
            tick_d_ff <= tick;
            if (tick) begin
                timer_ff <= timer_ff + 16'h0001;
            end
        end
    end

    // ********************************
    // Capture channels
    // ********************************
    ctc_capture_chan #(
        .WIDTH(16)
    ) u_capture_one (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_gpio[0]),
        .i_enable(capture_one_pin_enable),
        .i_rising(timer_channel_control_ff[`CTC_CTRL_CAP1_EDGE]),
        .i_timer(timer_ff),
        .o_value(capture_one_value),
        .o_event(o_capture_one_event)
    );

    ctc_capture_chan #(
        .WIDTH(16)
    ) u_capture_two (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_gpio[1]),
        .i_enable(capture_two_pin_enable),
        .i_rising(timer_channel_control_ff[`CTC_CTRL_CAP2_EDGE]),
        .i_timer(timer_ff),
        .o_value(capture_two_value),
        .o_event(o_capture_two_event)
    );

    // ********************************
    // Compare channels
    // ********************************
    // Checked once per timer step so a match fires once, not for every
    // system clock in which the count sits at the compare value
    assign cmp_hit[0] = tick_d_ff && (timer_ff == compare_one_ff);
    assign cmp_hit[1] = tick_d_ff && (timer_ff == compare_two_ff);

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            cmp_out_ff <= 2'b00;
        end else begin
            if (cmp_hit[0]) begin
                cmp_out_ff[0] <= timer_channel_control_ff[`CTC_CTRL_CMP1_LVL];
            end
            if (cmp_hit[1]) begin
                cmp_out_ff[1] <= timer_channel_control_ff[`CTC_CTRL_CMP2_LVL];
            end
        end
    end

    assign o_compare_one_match = cmp_hit[0];
    assign o_compare_two_match = cmp_hit[1];

    // ********************************
    // Pin routing
    // ********************************
    // Capture pins are only ever inputs here; compare pins are driven only
    // while routed, otherwise the general pin logic owns them
    assign o_gpio = {cmp_out_ff[1], cmp_out_ff[0], 2'b00};
    assign o_gpio_oe_n[0] = 1'b1;
    assign o_gpio_oe_n[1] = 1'b1;
    assign o_gpio_oe_n[2] = ~compare_one_pin_enable;
    assign o_gpio_oe_n[3] = ~compare_two_pin_enable;
    assign o_gpio_claimed = timer_pin_routing_ff[3:0];

    // ********************************
    // Register writes
    // ********************************
    assign snap_req = i_sfr_wr && (i_sfr_addr == `CTC_ADDR_CTRL) &&
                      i_sfr_wdata[`CTC_CTRL_SNAP];

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            timer_channel_control_ff <= `CTC_RST_BYTE;
            timer_pin_routing_ff <= `CTC_RST_BYTE;
            compare_one_ff <= `CTC_RST_WORD;
            compare_two_ff <= `CTC_RST_WORD;
        end else if (i_sfr_wr) begin
            case (i_sfr_addr)
                `CTC_ADDR_CTRL: begin
                    // Snapshot bit is a strobe and is never stored
                    timer_channel_control_ff <= i_sfr_wdata & ~(8'h01 << `CTC_CTRL_SNAP);
                end
                `CTC_ADDR_ROUTE: begin
                    timer_pin_routing_ff <= i_sfr_wdata & `CTC_ROUTE_USED_MASK;
                end
                `CTC_ADDR_CMP1_HI: begin
                    compare_one_ff[15:8] <= i_sfr_wdata;
                end
                `CTC_ADDR_CMP1_LO: begin
                    compare_one_ff[7:0] <= i_sfr_wdata;
                end
                `CTC_ADDR_CMP2_HI: begin
                    compare_two_ff[15:8] <= i_sfr_wdata;
                end
                `CTC_ADDR_CMP2_LO: begin
                    compare_two_ff[7:0] <= i_sfr_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Shadow only changes on a snapshot, so software reads both bytes of
    // one coherent count while the timer keeps running
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            timer_shadow_ff <= `CTC_RST_WORD;
        end else if (snap_req) begin
            timer_shadow_ff <= timer_ff;
        end
    end

    // ********************************
    // Register reads
    // ********************************
    always @* begin
        case (i_sfr_addr)
            `CTC_ADDR_CTRL: nxt_rdata = timer_channel_control_ff;
            `CTC_ADDR_CAP1_HI: nxt_rdata = capture_one_value[15:8];
            `CTC_ADDR_CAP1_LO: nxt_rdata = capture_one_value[7:0];
            `CTC_ADDR_CAP2_HI: nxt_rdata = capture_two_value[15:8];
            `CTC_ADDR_CAP2_LO: nxt_rdata = capture_two_value[7:0];
            `CTC_ADDR_CMP1_HI: nxt_rdata = compare_one_ff[15:8];
            `CTC_ADDR_CMP1_LO: nxt_rdata = compare_one_ff[7:0];
            `CTC_ADDR_ROUTE: nxt_rdata = timer_pin_routing_ff;
            `CTC_ADDR_CMP2_HI: nxt_rdata = compare_two_ff[15:8];
            `CTC_ADDR_CMP2_LO: nxt_rdata = compare_two_ff[7:0];
            `CTC_ADDR_SHD_HI: nxt_rdata = timer_shadow_ff[15:8];
            `CTC_ADDR_SHD_LO: nxt_rdata = timer_shadow_ff[7:0];
            default: nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_ff <= 8'h00;
        end else if (i_sfr_rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_sfr_rdata = rdata_ff;
    assign o_pulldown_sel = timer_channel_control_ff[`CTC_CTRL_RES_HI:`CTC_CTRL_RES_LO];

endmodule

// >>> tb/ctc_timer_regs_monitor.sv
// Assertion checker for the capture/compare timer register block
`timescale 1ns/10ps
module ctc_timer_regs_monitor (
    // Clock and reset
    input wire i_clk,
    input wire i_sys_rst,
    // Register port
    input wire [7:0] i_sfr_addr,
    input wire i_sfr_wr,
    input wire [7:0] i_sfr_wdata,
    input wire i_sfr_rd,
    input wire [7:0] o_sfr_rdata,
    // Pins and events
    input wire [3:0] i_gpio,
    input wire [3:0] o_gpio,
    input wire [3:0] o_gpio_oe_n,
    input wire [3:0] o_gpio_claimed,
    input wire o_capture_one_event,
    input wire o_capture_two_event,
    input wire o_compare_one_match,
    input wire o_compare_two_match,
    input wire [1:0] o_pulldown_sel
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire rt_wr = i_sfr_wr && i_sfr_addr == 8'hC7;
    reg [1:0] lvl_ff;
    // Copy of the match level bits, the outputs cannot be judged without it
    always @(posedge i_clk) begin
        if (i_sys_rst)
            lvl_ff <= 2'h0;
        else if (i_sfr_wr && i_sfr_addr == 8'hC0)
            lvl_ff <= i_sfr_wdata[4:3];
    end
    route_one_a: assert property (rt_wr |=> o_gpio_claimed[0] == $past(i_sfr_wdata[0]))
        else $error("routing bit 0 lost");
    route_two_a: assert property (rt_wr |=> o_gpio_claimed[1] == $past(i_sfr_wdata[1]))
        else $error("routing bit 1 lost");
    cmp_one_pin_a: assert property (rt_wr |=> o_gpio_oe_n[2] == !$past(i_sfr_wdata[2]))
        else $error("pin three enable wrong");
    cmp_two_pin_a: assert property (rt_wr |=> o_gpio_oe_n[3] == !$past(i_sfr_wdata[3])
        && o_gpio_oe_n[1:0] == 2'h3) else $error("pin four enable wrong");
    route_high_a: assert property (i_sfr_rd && i_sfr_addr == 8'hC7 |=> o_sfr_rdata[7:4] == 4'h0)
        else $error("idle routing bits read set");
    rst_clear_a: assert property ($fell(i_sys_rst) |-> o_sfr_rdata == 8'h00
        && o_gpio_claimed == 4'h0) else $error("state not clear after reset");
    snap_read_a: assert property (i_sfr_rd && i_sfr_addr == 8'hC0 |=> !o_sfr_rdata[5])
        else $error("snapshot bit reads set");
    level_one_a: assert property (o_compare_one_match |=> o_gpio[2] == $past(lvl_ff[0]))
        else $error("compare one level wrong");
    level_two_a: assert property (o_compare_two_match |=> o_gpio[3] == $past(lvl_ff[1]))
        else $error("compare two level wrong");
    cap_route_a: assert property (o_capture_two_event |-> o_gpio_claimed[1])
        else $error("capture without routing");
    match_pulse_a: assert property (o_compare_one_match |=> !o_compare_one_match)
        else $error("match pulse too long");
    cover property (o_capture_one_event);
    cover property (o_capture_two_event);
    cover property (o_compare_two_match);
endmodule

bind ctc_timer_regs ctc_timer_regs_monitor mon (
    .i_clk, .i_sys_rst, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata,
    .i_gpio, .o_gpio, .o_gpio_oe_n, .o_gpio_claimed, .o_capture_one_event,
    .o_capture_two_event, .o_compare_one_match, .o_compare_two_match, .o_pulldown_sel
);

// >>> tb/ctc_pin_model.sv
// Far side: signal sources on pins one and two, loads on pins three and four
`timescale 1ns/10ps
module ctc_pin_model (
    // Clock
    input wire i_clk,
    // Source levels for pins one and two
    input wire [1:0] i_src,
    // Device drive
    input wire [3:0] i_drv,
    input wire [3:0] i_drv_oe_n,
    // Resolved pin levels
    output wire [3:0] o_pin
);
    reg tgl_ff = 1'b0;
    // Undriven pins wander, so a stale level never passes for the drive
    always @(negedge i_clk) begin
        tgl_ff <= ~tgl_ff;
    end
    assign o_pin[1:0] = i_src;
    assign o_pin[2] = i_drv_oe_n[2] ? tgl_ff : i_drv[2];
    assign o_pin[3] = i_drv_oe_n[3] ? ~tgl_ff : i_drv[3];
endmodule

// >>> tb/ctc_timer_regs_bench.sv
// Self-checking bench for the capture/compare timer register block
`timescale 1ns/10ps
module ctc_timer_regs_bench;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] src = 2'h0;
    wire [7:0] rdata;
    wire [3:0] pin, drv, oe_n, ev;
    wire [1:0] pd;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int c1 = 0;
    int c2 = 0;
    logic [15:0] va, vb;
    logic [7:0] b;
    // Address, data written, value read back
    logic [23:0] rows [10] = '{24'hC5A5A5, 24'hC65A5A, 24'hC93C3C, 24'hCAC3C3, 24'hC3FF00,
        24'hC4FF00, 24'hCBFF00, 24'hCCFF00, 24'hC8FF00, 24'hC7FF0F};
    always #5 i_clk = ~i_clk;
    ctc_pin_model pm (.i_clk(i_clk), .i_src(src), .i_drv(drv), .i_drv_oe_n(oe_n), .o_pin(pin));
    ctc_timer_regs dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_gpio(pin),
        .o_gpio(drv), .o_gpio_oe_n(oe_n), .o_gpio_claimed(),
        .o_capture_one_event(ev[0]), .o_capture_two_event(ev[1]),
        .o_compare_one_match(ev[2]), .o_compare_two_match(ev[3]), .o_pulldown_sel(pd)
    );
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        addr = a;
        rd = 1'b1;
        @(negedge i_clk);
        rd = 1'b0;
        d = rdata;
    endtask
    task automatic snap(input logic [7:0] c, output logic [15:0] v);
        wr_reg(8'hC0, c | 8'h20);
        rd_reg(8'hCB, v[15:8]);
        rd_reg(8'hCC, v[7:0]);
    endtask
    task automatic wait_ev(input int k);
        int n;
        n = 0;
        while (ev[k] !== 1'b1 && n < 400) begin
            @(negedge i_clk);
            n++;
        end
        chk(n < 400, 16'h0001);
    endtask
    // Sampled at the edge, so each one-cycle event counts once
    always @(posedge i_clk) begin
        cyc++;
        if (!i_sys_rst) begin
            c1 += ev[0];
            c2 += ev[1];
        end
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(negedge i_clk);
        i_sys_rst = 1'b0;
        foreach (rows[i]) begin
            wr_reg(rows[i][23:16], rows[i][15:8]);
            rd_reg(rows[i][23:16], b);
            chk(b, rows[i][7:0]);
        end
        chk(oe_n, 4'h3);
        // ********************************
        // Timer rate and snapshot spacing
        // ********************************
        snap(8'h00, va);
        repeat (94) @(negedge i_clk);
        snap(8'h00, vb);
        chk(vb - va, 16'h0014);
        wr_reg(8'hC0, 8'h01);
        snap(8'h01, va);
        repeat (94) @(negedge i_clk);
        snap(8'h01, vb);
        chk(vb - va, 16'h000A);
        wr_reg(8'hC0, 8'h01);
        rd_reg(8'hCB, va[15:8]);
        rd_reg(8'hCC, va[7:0]);
        chk(va, vb);
        for (int l = 1; l >= 0; l--) begin
            snap(l ? 8'h18 : 8'h00, va);
            va = va + 16'h0014;
            vb = va + 16'h0001;
            wr_reg(8'hC5, va[15:8]);
            wr_reg(8'hC6, va[7:0]);
            wr_reg(8'hC9, vb[15:8]);
            wr_reg(8'hCA, vb[7:0]);
            wait_ev(2);
            @(negedge i_clk);
            chk(pin[2], l[0]);
            wait_ev(3);
            @(negedge i_clk);
            chk(pin[3], l[0]);
        end
        wr_reg(8'hC7, 8'h03);
        chk(oe_n, 4'hF);
        // ********************************
        // Capture: one rising, two falling
        // ********************************
        wr_reg(8'hC0, 8'h02);
        src = 2'h3;
        repeat (8) @(negedge i_clk);
        src = 2'h0;
        repeat (2) @(negedge i_clk);
        snap(8'h02, va);
        rd_reg(8'hC3, vb[15:8]);
        rd_reg(8'hC4, vb[7:0]);
        chk(vb, va);
        chk({c1[7:0], c2[7:0]}, 16'h0101);
        wr_reg(8'hC7, 8'h00);
        src = 2'h3;
        repeat (8) @(negedge i_clk);
        src = 2'h0;
        repeat (8) @(negedge i_clk);
        chk({c1[7:0], c2[7:0]}, 16'h0101);
        i_sys_rst = 1'b1;
        repeat (12) @(negedge i_clk);
        i_sys_rst = 1'b0;
        for (int a = 8'hC0; a <= 8'hCC; a++) begin
            rd_reg(a[7:0], b);
            chk(b, 8'h00);
        end
        chk(oe_n, 4'hF);
        // Snapshot bit is a strobe: upper control bits stay, bit 5 reads zero
        wr_reg(8'hC0, 8'hE0);
        rd_reg(8'hC0, b);
        chk(b, 8'hC0);
        chk(pd, 2'h3);
        print_verdict();
    end
endmodule
